// File: hdl/ct_supervision.sv
// Current transformer supervision with APB registers, events and interrupt.
// Assumes measurement inputs and their strobe come from logic on sys_clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "cts_cfg.svh"
module ct_supervision #(
	parameter int CW = 16,
	parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic meas_valid_i,
	input wire logic [CW-1:0] phase_a_current_i,
	input wire logic [CW-1:0] phase_b_current_i,
	input wire logic [CW-1:0] phase_c_current_i,
	input wire logic [CW-1:0] first_residual_input_i,
	input wire logic [CW-1:0] second_residual_input_i,
	input wire logic [CW-1:0] pos_seq_current_i,
	input wire logic [CW-1:0] neg_seq_current_i,
	input wire logic block_i,
	output logic alarm_o,
	output logic blocked_o,
	output logic evt_valid_o,
	output logic [1:0] evt_code_o,
	output logic [31:0] evt_time_o,
	output logic irq_o
);
	// ============================================================
	// Declarations
	logic [7:0] ctrl_r;
	logic [1:0] irq_stat_r, irq_mask_r;
	logic [31:0] alarm_cnt_r, block_cnt_r, time_ms_r;
	logic [$clog2(MS_CYCLES)-1:0] ms_cnt_r;
	logic ms_tick;
	logic [2:0] ld_idx_r, ld_idx_d_r;
	logic [CW-1:0] set_r [0:5];
	logic [CW-1:0] mem_rd;
	logic wr_go, set_wr, clr_alarm, clr_block;
	logic [2:0] blk_sync_r;
	logic blk_pin_r;
	logic [2:0] hi_r, lo_above_r, lo_below_r;
	logic ratio_r, seq_r, sum_r;
	logic res_on, all_ok, blocked_nxt, alarm_nxt;
	logic [CW-1:0] res_val, min_i, max_i;
	logic [CW+2:0] sum_abs;
	logic [CW-1:0] dly_cnt_r;
	logic [3:0] pend_r, pend_set, grant;
	logic [CW-1:0] ph [0:2];

	assign ph[0] = phase_a_current_i;
	assign ph[1] = phase_b_current_i;
	assign ph[2] = phase_c_current_i;

	// Compare a against b with a return band: above picks when a > b and
	// drops below 97 percent; below picks when a < b and drops above 103 percent.
	function automatic logic hyst(input logic prev, input logic above,
		input logic [39:0] a, input logic [39:0] b);
		logic [47:0] a1, bf, bd, br;
		a1 = 48'(a) * 48'(`PCT_FULL);
		bf = 48'(b) * 48'(`PCT_FULL);
		bd = 48'(b) * 48'(`PCT_DROP);
		br = 48'(b) * 48'(`PCT_RISE);
		if (above) begin
			hyst = prev ? (a1 >= bd) : (a1 > bf);
		end else begin
			hyst = prev ? (a1 <= br) : (a1 < bf);
		end
	endfunction

	// ============================================================
	// APB slave
	// One wait state lets read data come from a flip-flop.
	assign wr_go = psel_i & penable_i & pwrite_i & pready_o;
	assign set_wr = wr_go & (paddr_i[11:8] == `SET_WINDOW);
	assign clr_alarm = wr_go & (paddr_i == `REG_CMD) & pwdata_i[`CMD_CLR_ALARM];
	assign clr_block = wr_go & (paddr_i == `REG_CMD) & pwdata_i[`CMD_CLR_BLOCK];

	// Answer strobe, read data and error for unmapped addresses.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pready_o <= 1'b0;
			prdata_o <= '0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i & penable_i & ~pready_o;
			pslverr_o <= 1'b0;
			prdata_o <= '0;
			if (psel_i & penable_i & ~pready_o & ~pwrite_i) begin
				case (paddr_i)
					`REG_CTRL: prdata_o <= {24'h0, ctrl_r};
					`REG_STATUS: prdata_o <= {24'h0, sum_r | ~res_on, seq_r, ratio_r,
						|lo_below_r, |lo_above_r, ~|hi_r, blocked_o, alarm_o};
					`REG_IRQ_STAT: prdata_o <= {30'h0, irq_stat_r};
					`REG_IRQ_MASK: prdata_o <= {30'h0, irq_mask_r};
					`REG_ALARM_CNT: prdata_o <= alarm_cnt_r;
					`REG_BLOCK_CNT: prdata_o <= block_cnt_r;
					`REG_CMD: prdata_o <= '0;
					`REG_TIME: prdata_o <= time_ms_r;
					default: pslverr_o <= (paddr_i[11:8] != `SET_WINDOW);
				endcase
			end else if (psel_i & penable_i & ~pready_o) begin
				pslverr_o <= ~(paddr_i[11:8] == `SET_WINDOW || paddr_i == `REG_CTRL ||
					paddr_i == `REG_IRQ_STAT || paddr_i == `REG_IRQ_MASK ||
					paddr_i == `REG_CMD);
			end
		end
	end

	// Control and mask registers; the group field picks the live settings.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_r <= `CTRL_RESET;
			irq_mask_r <= '0;
		end else if (wr_go & (paddr_i == `REG_CTRL)) begin
			ctrl_r <= pwdata_i[7:0];
		end else if (wr_go & (paddr_i == `REG_IRQ_MASK)) begin
			irq_mask_r <= pwdata_i[1:0];
		end
	end

	// ============================================================
	// Setting groups
	settings_mem #(.W(CW), .AW(6)) u_mem (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.wr_en_i(set_wr),
		.wr_addr_i(paddr_i[7:2]),
		.wr_data_i(pwdata_i[CW-1:0]),
		.rd_addr_i({ctrl_r[`CTRL_GROUP_LSB +: 3], ld_idx_r}),
		.rd_data_o(mem_rd)
	);

	// Shadow copy of the active group, refreshed every six cycles so edits
	// and group changes apply while supervision keeps running.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ld_idx_r <= '0;
			ld_idx_d_r <= '0;
			for (int i = 0; i < 6; i++) begin
				set_r[i] <= '0;
			end
		end else begin
			ld_idx_r <= (ld_idx_r == 3'(cts_pkg::SW_DELAY)) ? 3'h0 : ld_idx_r + 3'h1;
			ld_idx_d_r <= ld_idx_r;
			set_r[ld_idx_d_r] <= mem_rd;
		end
	end

	// ============================================================
	// Block pin: three stages, a change counts once stages two and three agree.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			blk_sync_r <= '0;
			blk_pin_r <= 1'b0;
		end else begin
			blk_sync_r <= {blk_sync_r[1:0], block_i};
			if (blk_sync_r[1] == blk_sync_r[2]) begin
				blk_pin_r <= blk_sync_r[2];
			end
		end
	end

	// ============================================================
	// Threshold comparators
	assign res_on = ctrl_r[`CTRL_RES_EN] &
		(ctrl_r[`CTRL_RES_SEL_LSB +: 2] != cts_pkg::RES_NONE);

	// Residual source and phase extremes.
	always_comb begin
		logic [CW+2:0] s;
		s = '0;
		case (ctrl_r[`CTRL_RES_SEL_LSB +: 2])
			cts_pkg::RES_FIRST: res_val = first_residual_input_i;
			cts_pkg::RES_SECOND: res_val = second_residual_input_i;
			default: res_val = '0;
		endcase
		min_i = ph[0];
		max_i = ph[0];
		for (int i = 1; i < 3; i++) begin
			if (ph[i] < min_i) min_i = ph[i];
			if (ph[i] > max_i) max_i = ph[i];
		end
		s = (CW+3)'(ph[0]) + (CW+3)'(ph[1]) + (CW+3)'(ph[2]);
		if (!ctrl_r[`CTRL_POLARITY]) begin
			sum_abs = s + (CW+3)'(res_val);
		end else begin
			sum_abs = (s >= (CW+3)'(res_val)) ? s - (CW+3)'(res_val) : (CW+3)'(res_val) - s;
		end
	end

	// Comparator states advance on each fresh measurement set.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			hi_r <= '0;
			lo_above_r <= '0;
			lo_below_r <= '0;
			ratio_r <= 1'b0;
			seq_r <= 1'b0;
			sum_r <= 1'b0;
		end else if (meas_valid_i) begin
			for (int i = 0; i < 3; i++) begin
				hi_r[i] <= hyst(hi_r[i], 1'b1, 40'(ph[i]), 40'(set_r[cts_pkg::SW_HIGH]));
				lo_above_r[i] <= hyst(lo_above_r[i], 1'b1, 40'(ph[i]),
					40'(set_r[cts_pkg::SW_LOW]));
				lo_below_r[i] <= hyst(lo_below_r[i], 1'b0, 40'(ph[i]),
					40'(set_r[cts_pkg::SW_LOW]));
			end
			ratio_r <= hyst(ratio_r, 1'b0, 40'(min_i) * 40'(`PCT_FULL),
				40'(set_r[cts_pkg::SW_PH_RATIO]) * 40'(max_i));
			seq_r <= hyst(seq_r, 1'b1, 40'(neg_seq_current_i) * 40'(`PCT_FULL),
				40'(set_r[cts_pkg::SW_SEQ_RATIO]) * 40'(pos_seq_current_i));
			sum_r <= res_on & hyst(sum_r, 1'b1, 40'(sum_abs), 40'(set_r[cts_pkg::SW_SUM]));
		end
	end

	// The residual term only counts when monitoring is on.
	assign all_ok = ~|hi_r & |lo_above_r & |lo_below_r & ratio_r & seq_r
		& (sum_r | ~res_on);

	// ============================================================
	// Millisecond base for the delay and the time stamps.
	assign ms_tick = (ms_cnt_r == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ms_cnt_r <= '0;
			time_ms_r <= '0;
		end else begin
			ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
			if (ms_tick) time_ms_r <= time_ms_r + 32'h1;
		end
	end

	// Delay timer: counts held milliseconds, saturating, cleared on any loss.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			dly_cnt_r <= '0;
		end else if (!all_ok || blocked_nxt) begin
			dly_cnt_r <= '0;
		end else if (ms_tick && dly_cnt_r != '1) begin
			dly_cnt_r <= dly_cnt_r + 1'b1;
		end
	end

	assign blocked_nxt = blk_pin_r | ctrl_r[`CTRL_SW_BLOCK];
	assign alarm_nxt = all_ok & ~blocked_nxt & (dly_cnt_r >= set_r[cts_pkg::SW_DELAY]);

	// ============================================================
	// Outputs, counters and interrupt status.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			alarm_o <= 1'b0;
			blocked_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			alarm_o <= alarm_nxt;
			blocked_o <= blocked_nxt;
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	// A new event beats a clear arriving in the same cycle.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			alarm_cnt_r <= '0;
			block_cnt_r <= '0;
			irq_stat_r <= '0;
		end else begin
			if (alarm_nxt & ~alarm_o) begin
				alarm_cnt_r <= clr_alarm ? 32'h1 : alarm_cnt_r + 32'h1;
			end else if (clr_alarm) begin
				alarm_cnt_r <= '0;
			end
			if (blocked_nxt & ~blocked_o) begin
				block_cnt_r <= clr_block ? 32'h1 : block_cnt_r + 32'h1;
			end else if (clr_block) begin
				block_cnt_r <= '0;
			end
			irq_stat_r <= (irq_stat_r & ~((wr_go & (paddr_i == `REG_IRQ_STAT)) ?
				pwdata_i[1:0] : 2'b00)) | {blocked_nxt & ~blocked_o, alarm_nxt & ~alarm_o};
		end
	end

	// ============================================================
	// Event reporting: transitions queue as pending bits, one leaves per cycle.
	assign pend_set = {~blocked_nxt & blocked_o, blocked_nxt & ~blocked_o,
		~alarm_nxt & alarm_o, alarm_nxt & ~alarm_o};
	assign grant = pend_r & (~pend_r + 4'h1);

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pend_r <= '0;
			evt_valid_o <= 1'b0;
			evt_code_o <= '0;
			evt_time_o <= '0;
		end else begin
			pend_r <= (pend_r & ~grant) | pend_set;
			evt_valid_o <= |pend_r;
			evt_time_o <= time_ms_r;
			case (grant)
				4'h2: evt_code_o <= cts_pkg::EVT_ALARM_OFF;
				4'h4: evt_code_o <= cts_pkg::EVT_BLOCK_ON;
				4'h8: evt_code_o <= cts_pkg::EVT_BLOCK_OFF;
				default: evt_code_o <= cts_pkg::EVT_ALARM_ON;
			endcase
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_block; blocked_o |-> !alarm_o; endproperty
	a_block: assert property (p_block) else $error("Alarm while blocked.");
	property p_high; alarm_o |-> $past(~|hi_r); endproperty
	a_high: assert property (p_high) else $error("Alarm with phase above upper limit.");
	property p_lo_up; alarm_o |-> $past(|lo_above_r); endproperty
	a_lo_up: assert property (p_lo_up) else $error("Alarm with no phase above lower.");
	property p_lo_dn; alarm_o |-> $past(|lo_below_r); endproperty
	a_lo_dn: assert property (p_lo_dn) else $error("Alarm with no phase below lower.");
	property p_ratio; alarm_o |-> $past(ratio_r && seq_r); endproperty
	a_ratio: assert property (p_ratio) else $error("Alarm without ratio conditions.");
	property p_sum; alarm_o && $past(res_on) |-> $past(sum_r); endproperty
	a_sum: assert property (p_sum) else $error("Alarm without sum condition.");
	property p_delay; $rose(alarm_o) |-> $past(dly_cnt_r) >= $past(set_r[5]); endproperty
	a_delay: assert property (p_delay) else $error("Alarm before delay elapsed.");
	property p_drop; !all_ok |=> !alarm_o && dly_cnt_r == 0; endproperty
	a_drop: assert property (p_drop) else $error("Alarm kept after condition loss.");
	sequence s_on_evt; ##[1:4] (evt_valid_o && evt_code_o == 2'(cts_pkg::EVT_ALARM_ON)); endsequence
	property p_evt; $rose(alarm_o) |-> s_on_evt; endproperty
	a_evt: assert property (p_evt) else $error("Alarm rise not reported.");
endmodule // ct_supervision
`default_nettype wire

// File: hdl/cts_cfg.svh
// Constants of the current transformer supervision block: offsets, fields, counts.
// Assumes a 125 MHz system clock and a 32-bit APB register bus.
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH

// ============================================================
// Timing
`define CLK_PERIOD_NS 8
`define MS_NS 1000000
`define MEAS_PERIOD_MS 5
`define GROUP_COUNT 8

// ============================================================
// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00c
`define REG_ALARM_CNT 12'h010
`define REG_BLOCK_CNT 12'h014
`define REG_CMD 12'h018
`define REG_TIME 12'h01c
`define SET_WINDOW 4'h1

// ============================================================
// Control fields and reset value
`define CTRL_RES_EN 0
`define CTRL_RES_SEL_LSB 1
`define CTRL_POLARITY 3
`define CTRL_GROUP_LSB 4
`define CTRL_SW_BLOCK 7
`define CTRL_RESET 8'h00
`define CMD_CLR_ALARM 0
`define CMD_CLR_BLOCK 1

// ============================================================
// Hysteresis in percent
`define PCT_FULL 100
`define PCT_DROP 97
`define PCT_RISE 103

`endif

// File: hdl/cts_pkg.sv
// Types used by the supervision block: residual sources, event codes and setting words.
// Assumes cts_cfg.svh holds all numeric constants.
package cts_pkg;
	typedef enum logic [1:0] {RES_NONE, RES_FIRST, RES_SECOND, RES_UNUSED} res_src_e;
	typedef enum logic [1:0] {EVT_ALARM_ON, EVT_ALARM_OFF, EVT_BLOCK_ON, EVT_BLOCK_OFF} evt_code_e;
	typedef enum logic [2:0] {SW_HIGH, SW_LOW, SW_PH_RATIO, SW_SEQ_RATIO, SW_SUM, SW_DELAY,
		SW_SPARE0, SW_SPARE1} set_word_e;
endpackage

// File: hdl/settings_mem.sv
// Setting memory: one word array holding all setting groups.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/10ps
`default_nettype none
module settings_mem #(
	parameter int W = 16,
	parameter int AW = 6
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [W-1:0] wr_data_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [W-1:0] rd_data_o
);
	logic [W-1:0] mem_r [0:(1<<AW)-1];

	// Cleared on reset so that no group ever feeds unknown thresholds.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < (1<<AW); i++) begin
				mem_r[i] <= '0;
			end
		end else if (wr_en_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
	end

	// Registered read port.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem_r[rd_addr_i];
		end
	end
endmodule // settings_mem
`default_nettype wire

// File: verif/meas_source.sv
// Model of the upstream measurement stage that feeds the supervision block.
// Assumes one clock; values are packed a,b,c,res1,res2,pos,neg from bit 0 up.
`timescale 1ns/10ps
`default_nettype none
module meas_source #(
	parameter int PERIOD = 20
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [111:0] vals_i,
	output logic meas_valid_o,
	output logic [111:0] vals_o
);
	// ============================================================
	// Periodic delivery
	int cnt_r;
	logic [111:0] held_r;

	// One strobe per period with a fresh snapshot of every magnitude.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cnt_r <= 0;
			meas_valid_o <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
			meas_valid_o <= (cnt_r == PERIOD - 1);
			if (cnt_r == PERIOD - 1) begin
				held_r <= vals_i;
			end
		end
	end

	// Outside the strobe the bus shows garbage, so a design that samples late is caught.
	assign vals_o = meas_valid_o ? held_r : ~held_r;
endmodule // meas_source
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the current transformer supervision block.
// Assumes the measurement model in meas_source.sv and a shortened ms tick.
`timescale 1ns/10ps
`default_nettype none
`include "cts_cfg.svh"
module tb_top;
	logic sys_clk_i;
	logic sys_rst_i;
	logic psel_i;
	logic penable_i;
	logic pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic meas_valid;
	logic [111:0] vals;
	logic [111:0] meas;
	logic block_i;
	logic alarm_o;
	logic blocked_o;
	logic evt_valid_o;
	logic [1:0] evt_code_o;
	logic irq_o;
	logic [31:0] evt_time_o;
	// Shortened millisecond so the delay and time stamps fit a short run.
	localparam int MS_SIM = 10;
	int tb_edges;
	int num_errors;
	int cmp_count;
	logic [1:0] exp_q[$];
	logic [31:0] rd;
	logic er;
	logic [15:0] set_v[6] = '{16'h03e8, 16'h0064, 16'h0032, 16'h0014, 16'h0064, 16'h0003};

	// ============================================================
	// Clock, partner and design
	always #4 sys_clk_i = ~sys_clk_i;

	meas_source #(.PERIOD(20)) src (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.vals_i(vals), .meas_valid_o(meas_valid), .vals_o(meas));

	ct_supervision #(.MS_CYCLES(MS_SIM)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.meas_valid_i(meas_valid), .phase_a_current_i(meas[15:0]),
		.phase_b_current_i(meas[31:16]), .phase_c_current_i(meas[47:32]),
		.first_residual_input_i(meas[63:48]), .second_residual_input_i(meas[79:64]),
		.pos_seq_current_i(meas[95:80]), .neg_seq_current_i(meas[111:96]),
		.block_i(block_i), .alarm_o(alarm_o), .blocked_o(blocked_o),
		.evt_valid_o(evt_valid_o), .evt_code_o(evt_code_o), .evt_time_o(evt_time_o),
		.irq_o(irq_o));

	// Edges since reset release; the expected time stamp is derived from it.
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tb_edges <= 0;
		end else begin
			tb_edges <= tb_edges + 1;
		end
	end

	// ============================================================
	// Shared tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; the request holds until pready is sampled high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		// Answer, data and write all belong to the rising edge with pready high.
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		chk("pready wait", 32'h1, {31'h0, pready_o === 1'b1});
	endtask

	task rchk(input string nm, input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
		chk({nm, " err"}, {31'h0, ee}, {31'h0, er});
	endtask

	// Waits, bounded, for alarm (which 0) or blocked (which 1) to reach a level.
	task wait_for(input int which, input logic v);
		int n;
		n = 0;
		@(negedge sys_clk_i);
		while (((which == 0) ? alarm_o : blocked_o) !== v && n < 300) begin
			n++;
			@(negedge sys_clk_i);
		end
		chk(which == 0 ? "alarm_o" : "blocked_o", {31'h0, v},
			{31'h0, (which == 0) ? alarm_o : blocked_o});
	endtask

	task tend(input string nm);
		$display("Test %s finished, errors %0d", nm, num_errors);
	endtask

	task test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ============================================================
	// Event scoreboard: each pulse takes the oldest expected code.
	always @(negedge sys_clk_i) begin
		if (evt_valid_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("ERROR evt_code expected none seen %h", evt_code_o);
			end else begin
				chk("evt_code", {30'h0, exp_q.pop_front()}, {30'h0, evt_code_o});
				chk("evt_time", 32'((tb_edges - 1) / MS_SIM), evt_time_o);
			end
		end
	end

	// Watchdog sized well above the whole sequence.
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		num_errors++;
		test_done();
	end

	// ============================================================
	// Main sequence
	initial begin
		sys_clk_i = 1'b0;
		sys_rst_i = 1'b1;
		{psel_i, penable_i, pwrite_i, block_i} = 4'h0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		vals = 112'h0;
		num_errors = 0;
		cmp_count = 0;
		void'($urandom(32'had71));
		repeat (16) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		rchk("ctrl", `REG_CTRL, 32'h0, 1'b0);
		rchk("irq_mask", `REG_IRQ_MASK, 32'h0, 1'b0);
		rchk("unmapped", 12'h040, 32'h0, 1'b1);
		rchk("setting read", 12'h100, 32'h0, 1'b0);
		tend("registers");
		// Group 3 holds the working settings; the others stay cleared.
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, 12'h160 + 12'(i * 4), {16'h0, set_v[i]});
		end
		apb(1'b1, `REG_CTRL, {24'($urandom), 8'h30});
		apb(1'b1, `REG_IRQ_MASK, {30'($urandom), 2'h3});
		repeat (10) @(posedge sys_clk_i);
		vals[15:0] <= 16'(200 + $urandom % 100);
		vals[31:16] <= 16'(200 + $urandom % 100);
		vals[47:32] <= 16'($urandom % 20);
		// Negative sequence stays well above the ratio times positive sequence.
		vals[95:80] <= 16'(100 + $urandom % 50);
		vals[111:96] <= 16'(50 + $urandom % 20);
		exp_q.push_back(2'h0);
		@(posedge meas_valid);
		repeat (15) @(negedge sys_clk_i);
		chk("alarm early", 32'h0, {31'h0, alarm_o});
		wait_for(0, 1'b1);
		// The interrupt level follows the status bit one cycle later.
		@(negedge sys_clk_i);
		chk("irq_o", 32'h1, {31'h0, irq_o});
		rchk("alarm cnt", `REG_ALARM_CNT, 32'h1, 1'b0);
		tend("alarm");
		exp_q.push_back(2'h1);
		exp_q.push_back(2'h2);
		block_i <= 1'b1;
		wait_for(1, 1'b1);
		chk("alarm blocked", 32'h0, {31'h0, alarm_o});
		rchk("block cnt", `REG_BLOCK_CNT, 32'h1, 1'b0);
		exp_q.push_back(2'h3);
		exp_q.push_back(2'h0);
		block_i <= 1'b0;
		wait_for(1, 1'b0);
		wait_for(0, 1'b1);
		tend("block");
		// First residual equals the phase sum and cancels when subtracted.
		// The second sits well above it, so only the source choice decides.
		@(posedge sys_clk_i);
		vals[63:48] <= vals[15:0] + vals[31:16] + vals[47:32];
		vals[79:64] <= vals[15:0] + vals[31:16] + vals[47:32] + 16'(200 + $urandom % 100);
		exp_q.push_back(2'h1);
		apb(1'b1, `REG_CTRL, 32'h3b);
		wait_for(0, 1'b0);
		exp_q.push_back(2'h0);
		apb(1'b1, `REG_CTRL, 32'h3d);
		wait_for(0, 1'b1);
		exp_q.push_back(2'h1);
		apb(1'b1, `REG_CTRL, 32'h3b);
		wait_for(0, 1'b0);
		exp_q.push_back(2'h0);
		apb(1'b1, `REG_CTRL, 32'h33);
		wait_for(0, 1'b1);
		tend("residual");
		exp_q.push_back(2'h1);
		@(posedge sys_clk_i);
		vals[47:32] <= vals[15:0];
		wait_for(0, 1'b0);
		tend("condition loss");
		apb(1'b1, `REG_CMD, 32'h3);
		rchk("alarm cnt clr", `REG_ALARM_CNT, 32'h0, 1'b0);
		apb(1'b1, `REG_IRQ_STAT, 32'h3);
		repeat (2) @(negedge sys_clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		repeat (20) @(negedge sys_clk_i);
		chk("events left", 32'h0, 32'(exp_q.size()));
		tend("clear");
		test_done();
	end
endmodule // tb_top
`default_nettype wire
